// *** pkg/okf_consts.svh ***
// Offsets, field positions, reset values and fetch rates of the key block.
// Assumes a 32-bit register bus and byte offsets taken from haddr[7:0].
// Behaviour
// - Source keying: masked overlay match shows iterated.
// - Key enable 1 keys; target 0 source, 1 destination.
// - Destination keying: masked iterated match shows overlay.
// - Zero mask disables compare; raster operation applies.
// - Palette rates 32/16/8/4; no rotation.
// - Rotation optimization holds bus lock asserted where the format supports it.
// - RGB burst rates 2, 1, packed 1.333.
// - Rotated RGB/AYUV: 0.2 normal, 1 optimized; packed RGB has no optimized rate.
// - AYUV 1 per cycle; packed 4:2:2 2, unrotated.
// - Semiplanar two streams, planar three streams.
// - One bus: 2 or 2.66; rotated 0.1 to 0.8.
// - Two buses: 4 burst; rotated 1 or 0.2.
// - Previous stage pixel is the iterated pixel.
`ifndef OKF_CONSTS_SVH
`define OKF_CONSTS_SVH
`define OKF_OFS_CTRL 8'h00
`define OKF_OFS_KEY 8'h04
`define OKF_OFS_MASK 8'h08
`define OKF_OFS_STATUS 8'h0C
`define OKF_OFS_RATE 8'h10
`define OKF_CTRL_KEN 0
`define OKF_CTRL_DST 1
`define OKF_CTRL_ROP 2
`define OKF_CTRL_FMT 4
`define OKF_CTRL_ROT 9
`define OKF_CTRL_OPT 10
`define OKF_CTRL_DUAL 11
`define OKF_CTRL_RST 12'h000
`define OKF_KEY_RST 24'h00_0000
`define OKF_MASK_RST 24'h00_0000
`define OKF_RATE_32 16'h7D00
`define OKF_RATE_16 16'h3E80
`define OKF_RATE_8 16'h1F40
`define OKF_RATE_4 16'h0FA0
`define OKF_RATE_2P66 16'h0A6A
`define OKF_RATE_2 16'h07D0
`define OKF_RATE_1P333 16'h0535
`define OKF_RATE_1 16'h03E8
`define OKF_RATE_0P8 16'h0320
`define OKF_RATE_0P66 16'h0294
`define OKF_RATE_0P5 16'h01F4
`define OKF_RATE_0P2 16'h00C8
`define OKF_RATE_0P16 16'h00A0
`define OKF_RATE_0P132 16'h0084
`define OKF_RATE_0P1 16'h0064
`define OKF_RATE_NONE 16'h0000
`endif

// *** pkg/okf_pkg.sv ***
// Types shared by the colour key and fetch-rate block.
// Assumes the constants header is included by the design files.
package okf_pkg;
  // Layer colour formats as held in the control register.
  typedef enum logic [4:0] {
    FMT_PAL1 = 5'h00, FMT_PAL2 = 5'h01, FMT_PAL4 = 5'h02,
    FMT_PAL8 = 5'h03, FMT_RGB12 = 5'h04, FMT_RGB16 = 5'h05,
    FMT_RGB18 = 5'h06, FMT_RGB18P = 5'h07, FMT_RGB19 = 5'h08,
    FMT_RGB19P = 5'h09, FMT_RGB24 = 5'h0A, FMT_RGB24P = 5'h0B,
    FMT_RGB25 = 5'h0C, FMT_RGB32 = 5'h0D, FMT_AYUV32 = 5'h0E,
    FMT_YUV422PK = 5'h0F, FMT_YUV422SP = 5'h10,
    FMT_YUV422PL = 5'h11, FMT_YUV420SP = 5'h12,
    FMT_YUV420PL = 5'h13
  } okf_fmt_t;
  // Raster operation applied while the mask is zero.
  typedef enum logic [1:0] {
    ROP_OVERLAY = 2'h0, ROP_ITERATED = 2'h1,
    ROP_AND = 2'h2, ROP_OR = 2'h3
  } okf_rop_t;
endpackage : okf_pkg

// *** design/okf_pair_buf.sv ***
// Small valid/ready buffer holding keyed pixels on their way out.
// Assumes one clock; the clock enable freezes every flip-flop.
`timescale 1ns/10ps
`default_nettype none
module okf_pair_buf #(
  parameter int W = 25,
  parameter int DEPTH = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data,
  output logic o_full
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_reg [DEPTH]; // Entry storage.
  logic [AW-1:0] wr_ptr_reg; // Next slot to fill.
  logic [AW-1:0] rd_ptr_reg; // Oldest slot.
  logic [AW:0] cnt_reg; // Entries held.
  logic push; // Word taken in.
  logic pop; // Word handed out.

  // Pointer step that also works for depths that are no power of two.
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : step

  // Full stalls the keying stage, so a stalled receiver loses nothing.
  assign o_full = (cnt_reg == (AW+1)'(DEPTH));
  assign o_in_ready = i_clk_en & ~o_full;
  assign o_out_valid = i_clk_en & (cnt_reg != '0);
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem_reg[rd_ptr_reg];

  // Storage and pointers; cleared so the data port is defined at reset.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= i_in_data;
        wr_ptr_reg <= step(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= step(rd_ptr_reg);
      end
    end
  end

  // Occupancy count; a push and a pop together leave it unchanged.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cnt_reg <= '0;
    end else if (push != pop) begin
      cnt_reg <= push ? cnt_reg + 1'b1 : cnt_reg - 1'b1;
    end
  end

  AST_BUF_COUNT: assert property (@(posedge i_ref_clk)
    disable iff (i_sys_rst)
    (push && !pop) |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("Buffer count did not rise on a push.");
endmodule : okf_pair_buf
`default_nettype wire

// *** design/okf_key_fetch.sv ***
// Overlay colour key stage with fetch-rate and bus-lock control.
// Assumes an AHB-Lite slave port, one clock and a frame pulse
// from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "okf_consts.svh"
module okf_key_fetch #(
  parameter int CW = 8,
  parameter int BUF_DEPTH = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  input wire logic i_frame_start,
  input wire logic i_pix_valid,
  output logic o_pix_ready,
  input wire logic [3*CW-1:0] i_iter_pixel,
  input wire logic [3*CW-1:0] i_ovl_pixel,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [3*CW-1:0] o_out_pixel,
  output logic o_out_match,
  output logic o_fetch_lock,
  output logic [15:0] o_fetch_rate,
  output logic [1:0] o_fetch_streams
);
  localparam int PW = 3 * CW;

  // Software copies, written over the bus.
  logic [11:0] ctrl_reg; // Control fields.
  logic [PW-1:0] key_reg; // Red, green, blue key.
  logic [PW-1:0] mask_reg; // Red, green, blue mask.
  // Active copies, loaded only at a frame boundary.
  logic [11:0] act_ctrl_reg;
  logic [PW-1:0] act_key_reg;
  logic [PW-1:0] act_mask_reg;
  // Bus data-phase bookkeeping.
  logic addr_ph; // Address phase taken this edge.
  logic wr_pend_reg; // A write data phase is due.
  logic [7:0] wr_ofs_reg; // Its byte offset.
  // Keying datapath.
  logic act_ken; // Keying on.
  logic act_dst; // Destination keying.
  okf_pkg::okf_rop_t act_rop; // Raster operation.
  okf_pkg::okf_fmt_t act_fmt; // Layer format.
  logic act_rot; // Rotated fetch.
  logic act_opt; // Rotation optimization.
  logic act_dual; // Two bus masters.
  logic [PW-1:0] probe; // Pixel under test.
  logic [2:0] comp_hit; // Per-component match.
  logic key_hit; // All components match.
  logic mask_zero; // Comparison disabled.
  logic [PW-1:0] result; // Selected pixel.
  logic result_match; // Key matched.
  logic buf_full; // Buffer holds two words.
  logic last_match_reg; // Match of last pixel.

  // Streams a format needs; anything above one is multi-plane.
  function automatic logic [1:0] streams(input okf_pkg::okf_fmt_t f);
    if (f == okf_pkg::FMT_YUV422SP || f == okf_pkg::FMT_YUV420SP) begin
      streams = 2'h2;
    end else if (f == okf_pkg::FMT_YUV422PL ||
                 f == okf_pkg::FMT_YUV420PL) begin
      streams = 2'h3;
    end else begin
      streams = 2'h1;
    end
  endfunction : streams

  // Fetch rate in thousandths of a pixel per cycle; zero means the
  // mode is not supported for that format.
  function automatic logic [15:0] rate(input okf_pkg::okf_fmt_t f,
                                       input logic rot,
                                       input logic opt,
                                       input logic dual);
    logic [15:0] burst;
    logic [15:0] r_opt;
    logic [15:0] r_norm;
    burst = `OKF_RATE_1;
    r_opt = `OKF_RATE_1;
    r_norm = `OKF_RATE_0P2;
    // Burst rates.
    case (f)
      okf_pkg::FMT_PAL1: burst = `OKF_RATE_32;
      okf_pkg::FMT_PAL2: burst = `OKF_RATE_16;
      okf_pkg::FMT_PAL4: burst = `OKF_RATE_8;
      okf_pkg::FMT_PAL8: burst = `OKF_RATE_4;
      okf_pkg::FMT_RGB12, okf_pkg::FMT_RGB16: burst = `OKF_RATE_2;
      okf_pkg::FMT_RGB18P, okf_pkg::FMT_RGB19P,
      okf_pkg::FMT_RGB24P: burst = `OKF_RATE_1P333;
      okf_pkg::FMT_YUV422PK: burst = `OKF_RATE_2;
      okf_pkg::FMT_YUV422SP,
      okf_pkg::FMT_YUV422PL: burst = `OKF_RATE_2;
      okf_pkg::FMT_YUV420SP,
      okf_pkg::FMT_YUV420PL: burst = `OKF_RATE_2P66;
      default: burst = `OKF_RATE_1;
    endcase
    // Rotated rates with the bus lock held.
    case (f)
      okf_pkg::FMT_PAL1, okf_pkg::FMT_PAL2, okf_pkg::FMT_PAL4,
      okf_pkg::FMT_PAL8, okf_pkg::FMT_YUV422PK,
      okf_pkg::FMT_RGB18P, okf_pkg::FMT_RGB19P,
      okf_pkg::FMT_RGB24P: r_opt = `OKF_RATE_NONE;
      okf_pkg::FMT_YUV422SP,
      okf_pkg::FMT_YUV420PL: r_opt = `OKF_RATE_0P66;
      okf_pkg::FMT_YUV422PL: r_opt = `OKF_RATE_0P5;
      okf_pkg::FMT_YUV420SP: r_opt = `OKF_RATE_0P8;
      default: r_opt = `OKF_RATE_1;
    endcase
    // Rotated rates on random single accesses.
    case (f)
      okf_pkg::FMT_PAL1, okf_pkg::FMT_PAL2, okf_pkg::FMT_PAL4,
      okf_pkg::FMT_PAL8,
      okf_pkg::FMT_YUV422PK: r_norm = `OKF_RATE_NONE;
      okf_pkg::FMT_YUV422SP,
      okf_pkg::FMT_YUV420PL: r_norm = `OKF_RATE_0P132;
      okf_pkg::FMT_YUV422PL: r_norm = `OKF_RATE_0P1;
      okf_pkg::FMT_YUV420SP: r_norm = `OKF_RATE_0P16;
      default: r_norm = `OKF_RATE_0P2;
    endcase
    // A second master fetches the planes side by side.
    if (dual && streams(f) != 2'h1) begin
      burst = `OKF_RATE_4;
      r_opt = `OKF_RATE_1;
      r_norm = `OKF_RATE_0P2;
    end
    if (!rot) begin
      rate = burst;
    end else if (opt) begin
      rate = r_opt;
    end else begin
      rate = r_norm;
    end
  endfunction : rate

  // The slave never waits beyond a frozen clock enable, and never errs.
  assign o_hreadyout = i_clk_en;
  assign o_hresp = 1'b0;
  assign addr_ph = i_clk_en & i_hready & i_hsel & i_htrans[1];

  // Address phase capture; the write lands in the following cycle.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= 8'h00;
    end else if (i_clk_en) begin
      wr_pend_reg <= addr_ph & i_hwrite;
      if (addr_ph) begin
        wr_ofs_reg <= i_haddr[7:0];
      end
    end
  end

  // Software registers; unmapped and read-only offsets drop writes.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ctrl_reg <= `OKF_CTRL_RST;
      key_reg <= `OKF_KEY_RST;
      mask_reg <= `OKF_MASK_RST;
    end else if (i_clk_en && wr_pend_reg) begin
      if (wr_ofs_reg == `OKF_OFS_CTRL) begin
        ctrl_reg <= i_hwdata[11:0];
      end else if (wr_ofs_reg == `OKF_OFS_KEY) begin
        key_reg <= i_hwdata[PW-1:0];
      end else if (wr_ofs_reg == `OKF_OFS_MASK) begin
        mask_reg <= i_hwdata[PW-1:0];
      end
    end
  end

  // Read data is registered at the address phase and stands in the
  // data phase; a read right after a write sees the old value.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (addr_ph && !i_hwrite) begin
      if (i_haddr[7:0] == `OKF_OFS_CTRL) begin
        o_hrdata <= {20'h0_0000, ctrl_reg};
      end else if (i_haddr[7:0] == `OKF_OFS_KEY) begin
        o_hrdata <= 32'(key_reg);
      end else if (i_haddr[7:0] == `OKF_OFS_MASK) begin
        o_hrdata <= 32'(mask_reg);
      end else if (i_haddr[7:0] == `OKF_OFS_STATUS) begin
        o_hrdata <= {26'h000_0000, (o_fetch_rate == `OKF_RATE_NONE),
                     buf_full, last_match_reg, mask_zero,
                     act_dst, act_ken};
      end else if (i_haddr[7:0] == `OKF_OFS_RATE) begin
        o_hrdata <= {13'h0000, o_fetch_lock, o_fetch_streams,
                     o_fetch_rate};
      end else begin
        o_hrdata <= 32'h0000_0000;
      end
    end
  end

  // Settings move to the active copies only at a frame boundary, so
  // no frame mixes old and new keys.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      act_ctrl_reg <= `OKF_CTRL_RST;
      act_key_reg <= `OKF_KEY_RST;
      act_mask_reg <= `OKF_MASK_RST;
    end else if (i_clk_en && i_frame_start) begin
      act_ctrl_reg <= ctrl_reg;
      act_key_reg <= key_reg;
      act_mask_reg <= mask_reg;
    end
  end

  // Field views of the active control word.
  assign act_ken = act_ctrl_reg[`OKF_CTRL_KEN];
  assign act_dst = act_ctrl_reg[`OKF_CTRL_DST];
  assign act_rop = okf_pkg::okf_rop_t'(act_ctrl_reg[`OKF_CTRL_ROP +: 2]);
  assign act_fmt = okf_pkg::okf_fmt_t'(act_ctrl_reg[`OKF_CTRL_FMT +: 5]);
  assign act_rot = act_ctrl_reg[`OKF_CTRL_ROT];
  assign act_opt = act_ctrl_reg[`OKF_CTRL_OPT];
  assign act_dual = act_ctrl_reg[`OKF_CTRL_DUAL];

  // Source keying tests the overlay; destination keying tests the
  // iterated pixel coming from the previous stage.
  assign probe = act_dst ? i_iter_pixel : i_ovl_pixel;
  assign mask_zero = (act_mask_reg == '0);

  // One masked comparator for each colour component.
  for (genvar g = 0; g < 3; g++) begin : g_comp
    assign comp_hit[g] = ((probe[g*CW +: CW] & act_mask_reg[g*CW +: CW])
                          == act_key_reg[g*CW +: CW]);
  end
  assign key_hit = &comp_hit;

  // Output selection; keying off lets the overlay cover the iterated
  // pixel, which is what the next stage would blend anyway.
  always_comb begin
    result = i_ovl_pixel;
    result_match = 1'b0;
    if (!act_ken) begin
      result = i_ovl_pixel;
    end else if (mask_zero) begin
      case (act_rop)
        okf_pkg::ROP_ITERATED: result = i_iter_pixel;
        okf_pkg::ROP_AND: result = i_iter_pixel & i_ovl_pixel;
        okf_pkg::ROP_OR: result = i_iter_pixel | i_ovl_pixel;
        default: result = i_ovl_pixel;
      endcase
    end else if (key_hit) begin
      result_match = 1'b1;
      result = act_dst ? i_ovl_pixel : i_iter_pixel;
    end else begin
      result = act_dst ? i_iter_pixel : i_ovl_pixel;
    end
  end

  // Keyed pixels wait here so that a stalled receiver loses none.
  okf_pair_buf #(
    .W(PW + 1),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_in_valid(i_pix_valid),
    .o_in_ready(o_pix_ready),
    .i_in_data({result_match, result}),
    .o_out_valid(o_out_valid),
    .i_out_ready(i_out_ready),
    .o_out_data({o_out_match, o_out_pixel}),
    .o_full(buf_full)
  );

  // Match of the last accepted pixel, shown in status.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      last_match_reg <= 1'b0;
    end else if (i_clk_en && i_pix_valid && o_pix_ready) begin
      last_match_reg <= result_match;
    end
  end

  // Fetch controls follow the active format; the lock is held only
  // for optimized rotation the format supports.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_fetch_rate <= `OKF_RATE_1;
      o_fetch_streams <= 2'h1;
      o_fetch_lock <= 1'b0;
    end else if (i_clk_en) begin
      o_fetch_rate <= rate(act_fmt, act_rot, act_opt, act_dual);
      o_fetch_streams <= streams(act_fmt);
      o_fetch_lock <= act_rot & act_opt &
        (rate(act_fmt, 1'b1, 1'b1, act_dual) != `OKF_RATE_NONE);
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_take;
    i_clk_en && i_pix_valid && o_pix_ready && act_ken && !mask_zero;
  endsequence
  sequence s_frame;
    i_clk_en && i_frame_start;
  endsequence

  AST_SRC_HIT: assert property (s_take and (!act_dst && key_hit)
    |-> result == i_iter_pixel)
    else $error("Source match did not keep the iterated pixel.");
  AST_DST_HIT: assert property (s_take and (act_dst && key_hit)
    |-> result == i_ovl_pixel && result_match)
    else $error("Destination match did not show the overlay.");
  AST_SRC_MISS: assert property (s_take and (!act_dst && !key_hit)
    |-> result == i_ovl_pixel && !result_match)
    else $error("Source miss did not show the overlay.");
  AST_ROP: assert property (act_ken && mask_zero &&
    act_rop == okf_pkg::ROP_AND
    |-> result == (i_iter_pixel & i_ovl_pixel) && !result_match)
    else $error("Zero mask did not apply the raster operation.");
  AST_ALL_COMP: assert property (result_match |-> act_ken &&
    ((probe & act_mask_reg) == act_key_reg))
    else $error("Match reported without all components equal.");
  AST_LOAD: assert property (s_frame |=> act_key_reg == $past(key_reg)
    && act_ctrl_reg == $past(ctrl_reg))
    else $error("Frame boundary did not load the settings.");
  AST_HOLD: assert property (!(i_clk_en && i_frame_start)
    |=> $stable(act_key_reg) && $stable(act_mask_reg))
    else $error("Key settings changed inside a frame.");
  AST_LOCK: assert property (i_clk_en && act_rot && act_opt &&
    act_fmt == okf_pkg::FMT_RGB32 |=> o_fetch_lock)
    else $error("Optimized rotation did not hold the lock.");
  AST_PAL_RATE: assert property (i_clk_en && act_fmt ==
    okf_pkg::FMT_PAL1 && !act_rot ##1 i_clk_en
    |-> (o_fetch_rate == 16'h7D00 || $past(i_sys_rst))
    ##1 (o_fetch_rate == 16'h7D00 || $past(i_frame_start, 2)))
    else $error("One-bit palette rate is not 32 per cycle.");
  AST_PACKED_ROT: assert property (i_clk_en && act_rot && act_opt &&
    act_fmt == okf_pkg::FMT_RGB24P |=> o_fetch_rate == 16'h0000
    && !o_fetch_lock)
    else $error("Packed RGB allowed optimized rotation.");
  AST_ROT_NORM: assert property (i_clk_en && act_rot && !act_opt &&
    act_fmt == okf_pkg::FMT_AYUV32 |=> o_fetch_rate == 16'h00C8)
    else $error("Rotated AYUV rate is not 0.2.");
  AST_YUV_PK: assert property (i_clk_en && !act_rot &&
    act_fmt == okf_pkg::FMT_YUV422PK |=> o_fetch_rate == 16'h07D0)
    else $error("Packed 4:2:2 rate is not 2.");
  AST_PLANES: assert property (i_clk_en &&
    act_fmt == okf_pkg::FMT_YUV420PL |=> o_fetch_streams == 2'h3)
    else $error("Planar layer is not fetched as three streams.");
  AST_ONE_BUS: assert property (i_clk_en && !act_dual && act_rot &&
    !act_opt && act_fmt == okf_pkg::FMT_YUV422PL
    |=> o_fetch_rate == 16'h0064)
    else $error("Single bus planar rotated rate is not 0.1.");
  AST_TWO_BUS: assert property (i_clk_en && act_dual && !act_rot &&
    act_fmt == okf_pkg::FMT_YUV420SP |=> o_fetch_rate == 16'h0FA0)
    else $error("Two bus semiplanar rate is not 4.");
endmodule : okf_key_fetch
`default_nettype wire

// *** verification/okf_pixel_sink.sv ***
// Receiver model standing after the key stage; it queues each taken word.
// Assumes one clock; the bench commands its stalls through i_stall.
`timescale 1ns/10ps
`default_nettype none
module okf_pixel_sink (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire logic [24:0] i_data,
  output logic o_ready
);
  // Taken words wait here for the bench, oldest first.
  logic [24:0] got_q[$];
  // Ready only drops while commanded, as a slow real receiver would.
  assign o_ready = !i_stall;
  // A word is taken only at an edge where valid and ready agree.
  always @(posedge i_clk) begin
    if (i_rst) begin
      got_q.delete();
    end else if (i_valid && o_ready) begin
      got_q.push_back(i_data);
    end
  end
endmodule : okf_pixel_sink
`default_nettype wire

// *** verification/okf_key_fetch_bench.sv ***
// Self-checking bench for the overlay key and fetch-rate stage.
// Assumes one AHB-Lite master here and the pixel receiver model.
`timescale 1ns/10ps
`default_nettype none
module okf_key_fetch_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready;
  logic [31:0] hrdata;
  logic hresp;
  logic frame = 1'b0;
  logic pvalid = 1'b0;
  logic pready;
  logic [23:0] iter = 24'h00_0000;
  logic [23:0] ovl = 24'h00_0000;
  logic ovalid;
  logic oready;
  logic [23:0] opix;
  logic omatch;
  logic stall = 1'b0;
  logic lock;
  logic [15:0] rate;
  logic [1:0] streams;
  int n_mismatch = 0;
  int tests_run = 0;
  // Clock of 40 ns.
  always #20 clk = ~clk;
  okf_key_fetch #(.CW(8), .BUF_DEPTH(2)) i_dut (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
    .i_frame_start(frame), .i_pix_valid(pvalid), .o_pix_ready(pready),
    .i_iter_pixel(iter), .i_ovl_pixel(ovl), .o_out_valid(ovalid),
    .i_out_ready(oready), .o_out_pixel(opix), .o_out_match(omatch),
    .o_fetch_lock(lock), .o_fetch_rate(rate), .o_fetch_streams(streams));
  okf_pixel_sink i_sink (.i_clk(clk), .i_rst(rst), .i_stall(stall),
    .i_valid(ovalid), .i_data({omatch, opix}), .o_ready(oready));
  // Shared comparison; an unknown never passes for a match.
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] gt);
    tests_run++;
    if (gt !== ex) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, ex, gt);
    end
  endtask : chk
  // One single word transfer; the master waits on hready, never counts.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] ex);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(nm, ex, q);
  endtask : rd_chk
  // Frame pulse; fetch outputs settle one edge after it is taken.
  task automatic frm;
    @(posedge clk);
    frame <= 1'b1;
    @(posedge clk);
    frame <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : frm
  // Holds a pixel pair until ready is seen settled at the falling edge.
  task automatic px(input logic [23:0] it, input logic [23:0] ov);
    @(posedge clk);
    pvalid <= 1'b1;
    iter <= it;
    ovl <= ov;
    do @(negedge clk); while (pready !== 1'b1);
    @(posedge clk);
    pvalid <= 1'b0;
  endtask : px
  // Bounded wait for the receiver to take a word, then compare it.
  task automatic got(input string nm, input logic [24:0] ex);
    int n;
    n = 0;
    while (i_sink.got_q.size() == 0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (i_sink.got_q.size() == 0) chk(nm, {7'h00, ex}, 32'hxxxx_xxxx);
    else chk(nm, {7'h00, ex}, {7'h00, i_sink.got_q.pop_front()});
  endtask : got
  task automatic t_reset;
    chk("fetch", 32'h0001_03E8, {13'h0000, lock, streams, rate});
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    rd_chk("ctrl", 8'h00, 32'h0000_0000);
    rd_chk("key", 8'h04, 32'h0000_0000);
    rd_chk("mask", 8'h08, 32'h0000_0000);
  endtask : t_reset
  // Read-only and unmapped places must keep nothing that is written.
  task automatic t_regs;
    wr(8'h00, 32'hFFFF_FFFF);
    rd_chk("ctrl", 8'h00, 32'h0000_0FFF);
    wr(8'h10, 32'h0000_0000);
    rd_chk("rate", 8'h10, 32'h0001_7D00);
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h40, 32'h0000_0000);
  endtask : t_regs
  // The second pair differs from the key in blue alone.
  task automatic t_src;
    wr(8'h04, 32'h0010_3050);
    wr(8'h08, 32'h00F0_F0F0);
    wr(8'h00, 32'h0000_0001);
    frm;
    px(24'h12_3456, 24'h1F_3A5B);
    got("src_hit", 25'h112_3456);
    rd_chk("status", 8'h0C, 32'h0000_0009);
    px(24'h12_3456, 24'h1F_3A6B);
    got("src_miss", 25'h01F_3A6B);
  endtask : t_src
  // Both pixels hit, so the result shows which mode is active.
  task automatic t_dst;
    wr(8'h00, 32'h0000_0003);
    px(24'h12_3456, 24'h1F_3A5B);
    got("old_frame", 25'h112_3456);
    frm;
    px(24'h12_3456, 24'h1F_3A5B);
    got("dst_hit", 25'h11F_3A5B);
    px(24'h77_7777, 24'h1F_3A5B);
    got("dst_miss", 25'h077_7777);
  endtask : t_dst
  task automatic t_rop;
    logic [23:0] ex [4] = '{24'h33_55AA, 24'h0F_F0CC, 24'h03_5088,
                            24'h3F_F5EE};
    wr(8'h08, 32'h0000_0000);
    for (int r = 0; r < 4; r++) begin
      wr(8'h00, {28'h000_0000, 2'(r), 2'h1});
      frm;
      px(24'h0F_F0CC, 24'h33_55AA);
      got("rop", {1'b0, ex[r]});
    end
    wr(8'h08, 32'h00F0_F0F0);
    wr(8'h00, 32'h0000_0000);
    frm;
    px(24'h12_3456, 24'h1F_3A5B);
    got("key_off", 25'h01F_3A5B);
  endtask : t_rop
  // A stalled receiver: two words fill the buffer and nothing is lost.
  task automatic t_buf;
    @(posedge clk);
    stall <= 1'b1;
    px(24'h00_0001, 24'h00_0011);
    px(24'h00_0002, 24'h00_0022);
    @(negedge clk);
    chk("full", 32'h0000_0000, {31'h0000_0000, pready});
    chk("held", 32'h0000_0011, {8'h00, opix});
    chk("valid", 32'h0000_0001, {31'h0000_0000, ovalid});
    @(posedge clk);
    stall <= 1'b0;
    got("first", 25'h000_0011);
    got("second", 25'h000_0022);
  endtask : t_buf
  // Expected word is lock, stream count and rate in thousandths.
  task automatic t_rate;
    logic [11:0] rc [20] = '{12'h000, 12'h010, 12'h020, 12'h030, 12'h600,
      12'h050, 12'h0B0, 12'h6D0, 12'h2D0, 12'h2F0, 12'h100, 12'h130,
      12'h720, 12'h310, 12'h930, 12'hB00, 12'h2E0, 12'h0F0, 12'h6B0,
      12'h920};
    logic [19:0] re [20] = '{20'h1_7D00, 20'h1_3E80, 20'h1_1F40,
      20'h1_0FA0, 20'h1_0000, 20'h1_07D0, 20'h1_0535, 20'h5_03E8,
      20'h1_00C8, 20'h1_0000, 20'h2_07D0, 20'h3_0A6A, 20'h6_0320,
      20'h3_0064, 20'h3_0FA0, 20'h2_00C8, 20'h1_00C8, 20'h1_07D0,
      20'h1_0000, 20'h2_0FA0};
    for (int i = 0; i < 20; i++) begin
      wr(8'h00, {20'h0_0000, rc[i]});
      frm;
      chk("fetch", {12'h000, re[i]}, {13'h0000, lock, streams, rate});
      rd_chk("rate_reg", 8'h10, {12'h000, re[i]});
    end
  endtask : t_rate
  task automatic tally_and_finish;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_src;
    t_dst;
    t_rop;
    t_buf;
    t_rate;
    tally_and_finish;
  end
  // Watchdog well beyond the roughly 350 cycles the tests need.
  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule : okf_key_fetch_bench
`default_nettype wire
